// ### adcsr_scan.sv
// Purpose: scan request source of a converter kernel with Avalon-MM register access
// Assumes: arbiter and sequencer run on sys_clk; gate and trigger pins are asynchronous
// Notes:   every bus access is answered one cycle after it is raised
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
`include "adcsr_map.svh"

// ***********************************************************
// scan request source top
// ***********************************************************
module adcsr_scan
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // avalon-mm slave
   input wire logic [8:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // external request pins
   input wire logic gate_input,
   input wire logic trigger_input,
   // request to the arbiter
   output logic req_valid,
   output logic [3:0] req_channel,
   // conversion status from the sequencer
   input wire logic conv_start,
   input wire logic conv_abort,
   input wire logic [3:0] conv_channel,
   input wire logic conv_done,
   // interrupt
   output logic irq
);

   // ***********************************************************
   // helpers
   // ***********************************************************

   // highest set bit of a channel vector, zero when empty
   function automatic logic [3:0] top_channel(input logic [15:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 0; i < 16; i++)
      begin
         if (v[i])
         begin
            r = i[3:0];
         end
      end
      return r;
   endfunction

   // byte-lane merge of a 16-bit register with write data
   function automatic logic [15:0] be_merge(
      input logic [15:0] old,
      input logic [15:0] wd,
      input logic [1:0] be
   );
      logic [15:0] r;
      r = old;
      if (be[0])
      begin
         r[7:0] = wd[7:0];
      end
      if (be[1])
      begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction

   // ***********************************************************
   // pin synchronisers
   // ***********************************************************

   adcsr_sync_if gate_s ();
   adcsr_sync_if trig_s ();

   // gate level is used as is, the rise is ignored
   adcsr_sync u_gate_sync
   (
      .sys_clk (sys_clk),
      .rst_n (rst_n),
      .pin (gate_input),
      .sync (gate_s)
   );

   // trigger rise becomes a load event when enabled
   adcsr_sync u_trig_sync
   (
      .sys_clk (sys_clk),
      .rst_n (rst_n),
      .pin (trigger_input),
      .sync (trig_s)
   );

   // ***********************************************************
   // state
   // ***********************************************************

   adcsr_pkg::adcsr_state_t q;
   adcsr_pkg::adcsr_state_t d;

   // bus decode
   logic wr_go;
   logic rd_go;
   logic wr_sel;
   logic wr_pend;
   logic wr_mode;
   logic wr_sts;
   logic wr_msk;
   logic [15:0] wd16;
   logic [15:0] new_sel;
   logic [15:0] new_mode;

   // events
   logic clr_cmd;
   logic software_load_command_cmd;
   logic src_evt;
   logic load_evt;
   logic gate_ok;
   logic [15:0] pend_n;
   logic [15:0] sel_n;

   // ***********************************************************
   // bus decode
   // ***********************************************************

   // writes land at the edge where waitrequest is seen low
   assign wr_go = avs_write & q.ack;
   assign rd_go = avs_read & ~avs_write & ~q.ack;
   assign wd16 = avs_writedata[15:0];
   assign wr_sel = wr_go && (avs_address == `ADCSR_IDX_SEL);
   assign wr_pend = wr_go && (avs_address == `ADCSR_IDX_PEND);
   assign wr_mode = wr_go && (avs_address == `ADCSR_IDX_MODE);
   assign wr_sts = wr_go && (avs_address == `ADCSR_IDX_STS);
   assign wr_msk = wr_go && (avs_address == `ADCSR_IDX_MSK);
   assign new_sel = be_merge(q.sel, wd16, avs_byteenable[1:0]);
   assign new_mode = be_merge(`ADCSR_ZERO_16, wd16, avs_byteenable[1:0]);
   // next select value kept apart from the state copy so pending logic does not loop through it
   assign sel_n = (wr_sel | wr_pend) ? new_sel : q.sel;

   // ***********************************************************
   // event sources
   // ***********************************************************

   // command bits are write-only pulses, never stored
   assign clr_cmd = wr_mode & new_mode[`ADCSR_BIT_CLEAR_PENDING_COMMAND];
   assign software_load_command_cmd = wr_mode & new_mode[`ADCSR_BIT_SOFTWARE_LOAD_COMMAND];

   // sequence end: our conversion finished and nothing left pending
   assign src_evt = conv_done & q.busy & (q.pend == `ADCSR_ZERO_16);

   // any of the four load sources
   assign load_evt = wr_pend
      | software_load_command_cmd
      | (q.trig_en & trig_s.rise)
      | (q.autoscan & src_evt);

   // ***********************************************************
   // gating
   // ***********************************************************

   // gating holds requests back but leaves pending bits alone
   always_comb
   begin
      case (q.gate_mode)
         adcsr_pkg::ADCSR_GATE_OFF: gate_ok = 1'b0;
         adcsr_pkg::ADCSR_GATE_ANY: gate_ok = 1'b1;
         adcsr_pkg::ADCSR_GATE_HIGH: gate_ok = gate_s.level;
         adcsr_pkg::ADCSR_GATE_LOW: gate_ok = ~gate_s.level;
         default: gate_ok = 1'b0;
      endcase
   end

   // ***********************************************************
   // pending bits
   // ***********************************************************

   // clear, then load, then start clears, abort set wins last
   always_comb
   begin
      pend_n = q.pend;
      if (clr_cmd)
      begin
         pend_n = `ADCSR_ZERO_16;
      end
      if (load_evt)
      begin
         if (q.load_mode)
         begin
            pend_n = pend_n | sel_n;
         end
         else
         begin
            pend_n = sel_n;
         end
      end
      if (conv_start)
      begin
         pend_n[conv_channel] = 1'b0;
      end
      if (conv_abort)
      begin
         pend_n[conv_channel] = 1'b1;
      end
   end

   // ***********************************************************
   // next state
   // ***********************************************************

   always_comb
   begin
      d = q;

      // select bits: direct write or via the pending address
      if (wr_sel | wr_pend)
      begin
         d.sel = new_sel;
      end

      // mode fields that are stored
      if (wr_mode)
      begin
         d.gate_mode = adcsr_pkg::adcsr_gate_t'(new_mode[`ADCSR_GATE_MSB:`ADCSR_GATE_LSB]);
         d.trig_en = new_mode[`ADCSR_BIT_TRIG];
         d.int_en = new_mode[`ADCSR_BIT_INT];
         d.autoscan = new_mode[`ADCSR_BIT_SCAN];
         d.load_mode = new_mode[`ADCSR_BIT_LDM];
      end

      d.pend = pend_n;

      // tracks a conversion of ours in flight
      if (conv_start)
      begin
         d.busy = 1'b1;
      end
      else if (conv_done | conv_abort)
      begin
         d.busy = 1'b0;
      end

      // sticky source event; a set in the clear cycle survives
      d.sts = (q.sts & ~(wr_sts & new_mode[`ADCSR_BIT_EVT])) | (src_evt & q.int_en);
      if (wr_msk)
      begin
         d.msk = new_mode[`ADCSR_BIT_EVT];
      end
      d.irq = d.sts & d.msk;

      // request registered from the next pending view
      d.req_v = (d.pend != `ADCSR_ZERO_16) & gate_ok;
      d.req_ch = top_channel(d.pend);

      // one-cycle answer: ack high for exactly one cycle per access
      d.ack = (avs_read | avs_write) & ~q.ack;
      d.wt = ~d.ack;

      // read data captured as the answer is raised
      if (rd_go)
      begin
         case (avs_address)
            `ADCSR_IDX_SEL: d.rdata = {`ADCSR_ZERO_16, q.sel};
            `ADCSR_IDX_PEND: d.rdata = {`ADCSR_ZERO_16, q.pend};
            `ADCSR_IDX_MODE:
            begin
               d.rdata = `ADCSR_RST_32;
               d.rdata[`ADCSR_GATE_MSB:`ADCSR_GATE_LSB] = q.gate_mode;
               d.rdata[`ADCSR_BIT_TRIG] = q.trig_en;
               d.rdata[`ADCSR_BIT_INT] = q.int_en;
               d.rdata[`ADCSR_BIT_SCAN] = q.autoscan;
               d.rdata[`ADCSR_BIT_LDM] = q.load_mode;
               d.rdata[`ADCSR_BIT_GLVL] = gate_s.level;
            end
            `ADCSR_IDX_STS:
            begin
               d.rdata = `ADCSR_RST_32;
               d.rdata[`ADCSR_BIT_EVT] = q.sts;
            end
            `ADCSR_IDX_MSK:
            begin
               d.rdata = `ADCSR_RST_32;
               d.rdata[`ADCSR_BIT_EVT] = q.msk;
            end
            default: d.rdata = `ADCSR_RST_32; // unmapped reads zero
         endcase
      end
   end

   // ***********************************************************
   // state register
   // ***********************************************************

   // everything clears; waitrequest idles high
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q.sel <= `ADCSR_RST_16;
         q.pend <= `ADCSR_RST_16;
         q.gate_mode <= adcsr_pkg::ADCSR_GATE_OFF;
         q.trig_en <= 1'b0;
         q.int_en <= 1'b0;
         q.autoscan <= 1'b0;
         q.load_mode <= 1'b0;
         q.busy <= 1'b0;
         q.sts <= 1'b0;
         q.msk <= 1'b0;
         q.ack <= 1'b0;
         q.wt <= 1'b1;
         q.rdata <= `ADCSR_RST_32;
         q.req_v <= 1'b0;
         q.req_ch <= 4'h0;
         q.irq <= 1'b0;
      end
      else
      begin
         q <= d;
      end
   end

   // ***********************************************************
   // outputs
   // ***********************************************************

   // all straight from flops
   assign avs_readdata = q.rdata;
   assign avs_waitrequest = q.wt;
   assign req_valid = q.req_v;
   assign req_channel = q.req_ch;
   assign irq = q.irq;

endmodule

// ### adcsr_map.svh
// Purpose: register indexes, field positions and reset values of the scan request source
// Assumes: indexes are Avalon word addresses; byte address is four times the index
// Notes:   definitions only
`ifndef ADCSR_MAP_SVH
`define ADCSR_MAP_SVH

// ***********************************************************
// register word indexes
// ***********************************************************
`define ADCSR_IDX_SEL 9'h0E8
`define ADCSR_IDX_PEND 9'h0EA
`define ADCSR_IDX_MODE 9'h0EC
`define ADCSR_IDX_STS 9'h0F0
`define ADCSR_IDX_MSK 9'h0F1

// ***********************************************************
// reset values and widths
// ***********************************************************
`define ADCSR_RST_16 16'h0000
`define ADCSR_RST_32 32'h0000_0000
`define ADCSR_ZERO_16 16'h0000

// ***********************************************************
// mode register fields
// ***********************************************************
`define ADCSR_GATE_MSB 1
`define ADCSR_GATE_LSB 0
`define ADCSR_BIT_TRIG 2
`define ADCSR_BIT_INT 3
`define ADCSR_BIT_SCAN 4
`define ADCSR_BIT_LDM 5
`define ADCSR_BIT_GLVL 7
`define ADCSR_BIT_CLEAR_PENDING_COMMAND 8
`define ADCSR_BIT_SOFTWARE_LOAD_COMMAND 9

// ***********************************************************
// status and mask fields
// ***********************************************************
`define ADCSR_BIT_EVT 0

`endif

// ### adcsr_pkg.sv
// Purpose: types shared by the scan request source modules
// Assumes: 16 channels, one module clock
// Notes:   offsets and field positions live in adcsr_map.svh
package adcsr_pkg;

   // gating behaviour of request issue
   typedef enum logic [1:0] {
      ADCSR_GATE_OFF = 2'h0,
      ADCSR_GATE_ANY = 2'h1,
      ADCSR_GATE_HIGH = 2'h2,
      ADCSR_GATE_LOW = 2'h3
   } adcsr_gate_t;

   // whole state of the main module
   typedef struct packed {
      logic [15:0] sel;
      logic [15:0] pend;
      adcsr_gate_t gate_mode;
      logic trig_en;
      logic int_en;
      logic autoscan;
      logic load_mode;
      logic busy;
      logic sts;
      logic msk;
      logic ack;
      logic wt;
      logic [31:0] rdata;
      logic req_v;
      logic [3:0] req_ch;
      logic irq;
   } adcsr_state_t;

   // whole state of the pin synchroniser
   typedef struct packed {
      logic s1;
      logic s2;
      logic prev;
   } adcsr_sync_state_t;

endpackage

// ### adcsr_sync_if.sv
// Purpose: carries a synchronised pin level and its rising edge
// Assumes: both ends on sys_clk
// Notes:   rise is a one-cycle pulse
`timescale 1ns/1ps
interface adcsr_sync_if;
   logic level;
   logic rise;
   modport src (output level, output rise);
   modport dst (input level, input rise);
endinterface

// ### adcsr_sync.sv
// Purpose: two-flop synchroniser with rising edge detect for one pin
// Assumes: pin is asynchronous to sys_clk
// Notes:   edge compares the synchronised sample with the one before it
`timescale 1ns/1ps
module adcsr_sync
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // raw pin
   input wire logic pin,
   // synchronised view
   adcsr_sync_if.src sync
);

   adcsr_pkg::adcsr_sync_state_t q;
   adcsr_pkg::adcsr_sync_state_t d;

   // first flop feeds only the second; edge looks at later stages
   always_comb
   begin
      d = q;
      d.s1 = pin;
      d.s2 = q.s1;
      d.prev = q.s2;
   end

   // state register
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   // level and one-cycle rise
   assign sync.level = q.s2;
   assign sync.rise = q.s2 & ~q.prev;

endmodule

// ### adcsr_scan_asserts.sv
// Purpose: port checks of the scan request source
// Assumes: one clock, bus answered one cycle after request
// Notes: gate field of mode and mask mirrored from taken writes
`timescale 1ns/1ps
`include "adcsr_map.svh"
// ****
// checker
// ****
module adcsr_scan_asserts
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // bus
   input wire logic [8:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic avs_waitrequest,
   // arbiter side and interrupt
   input wire logic req_valid,
   input wire logic [3:0] req_channel,
   input wire logic conv_start,
   input wire logic conv_abort,
   input wire logic [3:0] conv_channel,
   input wire logic conv_done,
   input wire logic irq
);
   logic [1:0] gate_q;
   logic msk_q;
   logic acc;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   assign acc = avs_write && !avs_waitrequest;
   // mirror, so gate and mask checks need no internal probes
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
      begin
         gate_q <= 2'h0;
         msk_q <= 1'b0;
      end
      else
      begin
         if (acc && avs_address == `ADCSR_IDX_MODE)
            gate_q <= avs_writedata[1:0];
         if (acc && avs_address == `ADCSR_IDX_MSK)
            msk_q <= avs_writedata[0];
      end
   a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus request not answered");
   a_gate_off: assert property (gate_q == 2'h0 && $past(gate_q) == 2'h0 |-> !req_valid)
      else $error("request issued with gating off");
   a_clear_req: assert property (acc && avs_address == `ADCSR_IDX_MODE && avs_writedata[8] |=> ##1 !req_valid)
      else $error("request after pending clear");
   a_start_next: assert property (conv_start && !conv_abort && req_valid && conv_channel == req_channel
      |=> ##1 !req_valid || req_channel != $past(conv_channel, 2))
      else $error("started channel still requested");
   a_irq_mask: assert property (!msk_q && !$past(msk_q) |-> !irq)
      else $error("interrupt while masked");
   // done seen one edge before irq rises; mask mirror updates at the same edge as the design
   a_irq_cause: assert property ($rose(irq) |-> $past(conv_done) || (msk_q && !$past(msk_q)))
      else $error("interrupt without cause");
   a_irq_clear: assert property (acc && avs_address == `ADCSR_IDX_STS && avs_writedata[0] && !conv_done
      |=> ##1 !irq)
      else $error("interrupt survives clear");
endmodule
bind adcsr_scan adcsr_scan_asserts i_chk (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_waitrequest(avs_waitrequest), .req_valid(req_valid), .req_channel(req_channel),
   .conv_start(conv_start), .conv_abort(conv_abort), .conv_channel(conv_channel),
   .conv_done(conv_done), .irq(irq));

// ### adcsr_seq_model.sv
// Purpose: behavioural arbiter and sequencer facing the scan source
// Assumes: grants every request, one conversion at a time
// Notes: dly sets conversion length, abort_en aborts instead of finishing
`timescale 1ns/1ps
module adcsr_seq_model
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // bench control
   input wire logic [7:0] dly,
   input wire logic abort_en,
   // request in, status out
   input wire logic req_valid,
   input wire logic [3:0] req_channel,
   output logic conv_start,
   output logic conv_abort,
   output logic conv_done,
   output logic [3:0] conv_channel
);
   logic busy;
   logic [7:0] cnt;
   logic [3:0] ch;
   // channel toggles between pulses so a stale value is never trusted
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
      begin
         busy <= 1'b0;
         cnt <= 8'h00;
         ch <= 4'h0;
         conv_start <= 1'b0;
         conv_abort <= 1'b0;
         conv_done <= 1'b0;
         conv_channel <= 4'h0;
      end
      else
      begin
         conv_start <= 1'b0;
         conv_abort <= 1'b0;
         conv_done <= 1'b0;
         conv_channel <= ~conv_channel;
         if (!busy && req_valid)
         begin
            busy <= 1'b1;
            cnt <= dly;
            ch <= req_channel;
            conv_start <= 1'b1;
            conv_channel <= req_channel;
         end
         else if (busy && cnt != 8'h00)
            cnt <= cnt - 8'h01;
         else if (busy)
         begin
            busy <= 1'b0;
            conv_channel <= ch;
            conv_abort <= abort_en;
            conv_done <= !abort_en;
         end
      end
endmodule

// ### adcsr_scan_tb.sv
// Purpose: self-checking bench of the scan request source
// Assumes: sequencer model on the arbiter side
// Notes: byte enables tied to all lanes
`timescale 1ns/1ps
`include "adcsr_map.svh"
// ****
// bench
// ****
module adcsr_scan_tb;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [8:0] avs_address = 9'h000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic gate_input = 1'b0;
   logic trigger_input = 1'b0;
   logic req_valid, conv_start, conv_abort, conv_done, irq;
   logic [3:0] req_channel, conv_channel;
   logic [7:0] dly = 8'h03;
   logic abort_en = 1'b0;
   int n_fail = 0;
   int n_checks = 0;
   logic [3:0] starts[$];
   always #5 sys_clk = ~sys_clk;
   adcsr_scan i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .gate_input(gate_input),
      .trigger_input(trigger_input), .req_valid(req_valid), .req_channel(req_channel),
      .conv_start(conv_start), .conv_abort(conv_abort), .conv_channel(conv_channel),
      .conv_done(conv_done), .irq(irq));
   adcsr_seq_model i_seq (.sys_clk(sys_clk), .rst_n(rst_n), .dly(dly), .abort_en(abort_en),
      .req_valid(req_valid), .req_channel(req_channel), .conv_start(conv_start),
      .conv_abort(conv_abort), .conv_done(conv_done), .conv_channel(conv_channel));
   // log of started channels, in order
   always @(posedge sys_clk)
      if (conv_start === 1'b1)
         starts.push_back(conv_channel);
   task automatic conclude();
      if (n_fail == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         n_fail++;
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // one Avalon access; an idle edge after it keeps drivers apart
   task automatic bus(input logic w, input logic [8:0] a, input logic [15:0] d, output logic [31:0] q);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {16'h0000, d};
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0)
         @(posedge sys_clk);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [8:0] a, input logic [15:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rdc(input logic [8:0] a, input logic [15:0] e, input string nm);
      logic [31:0] q;
      bus(1'b0, a, 16'h0000, q);
      chk(nm, q, {16'h0000, e});
   endtask
   task automatic wait_starts(input int n);
      for (int i = 0; i < 300 && starts.size() < n; i++)
         @(posedge sys_clk);
      chk("starts", starts.size(), n);
   endtask
   task automatic t_reset();
      logic [8:0] ra[6] = '{`ADCSR_IDX_SEL, `ADCSR_IDX_PEND, `ADCSR_IDX_MODE, `ADCSR_IDX_STS,
         `ADCSR_IDX_MSK, 9'h1FF};
      chk("irq", irq, 0);
      chk("req_valid", req_valid, 0);
      foreach (ra[i])
         rdc(ra[i], 16'h0000, "reset value");
   endtask
   task automatic t_sel();
      wr(`ADCSR_IDX_SEL, 16'h8421);
      wr(9'h1FF, 16'hFFFF);
      rdc(`ADCSR_IDX_SEL, 16'h8421, "select");
      rdc(`ADCSR_IDX_PEND, 16'h0000, "no load");
      rdc(9'h1FF, 16'h0000, "unmapped");
   endtask
   task automatic t_load();
      wr(`ADCSR_IDX_PEND, 16'hA000);
      rdc(`ADCSR_IDX_SEL, 16'hA000, "select via pending");
      rdc(`ADCSR_IDX_PEND, 16'hA000, "pending");
      chk("gate off", req_valid, 0);
      wr(`ADCSR_IDX_SEL, 16'h0003);
      wr(`ADCSR_IDX_MODE, 16'h0020);
      wr(`ADCSR_IDX_MODE, 16'h0220);
      rdc(`ADCSR_IDX_PEND, 16'hA003, "or load");
      wr(`ADCSR_IDX_MODE, 16'h0000);
      wr(`ADCSR_IDX_MODE, 16'h0200);
      rdc(`ADCSR_IDX_PEND, 16'h0003, "copy load");
      wr(`ADCSR_IDX_MODE, 16'h0100);
      rdc(`ADCSR_IDX_PEND, 16'h0000, "cleared");
   endtask
   task automatic t_seq();
      logic [3:0] ex[3] = '{4'hF, 4'h2, 4'h0};
      wr(`ADCSR_IDX_MSK, 16'h0001);
      wr(`ADCSR_IDX_MODE, 16'h0009);
      starts.delete();
      wr(`ADCSR_IDX_PEND, 16'h8005);
      for (int i = 0; i < 300 && irq !== 1'b1; i++)
         @(posedge sys_clk);
      chk("irq", irq, 1);
      chk("count", starts.size(), 3);
      foreach (ex[i])
         chk("order", starts[i], ex[i]);
      rdc(`ADCSR_IDX_STS, 16'h0001, "status");
      wr(`ADCSR_IDX_MSK, 16'h0000);
      cyc(2);
      chk("irq masked", irq, 0);
      wr(`ADCSR_IDX_MSK, 16'h0001);
      cyc(2);
      chk("irq unmasked", irq, 1);
      wr(`ADCSR_IDX_STS, 16'h0001);
      cyc(2);
      chk("irq cleared", irq, 0);
      rdc(`ADCSR_IDX_STS, 16'h0000, "status cleared");
   endtask
   task automatic t_gate();
      wr(`ADCSR_IDX_MODE, 16'h0000);
      wr(`ADCSR_IDX_PEND, 16'hFFFF);
      wr(`ADCSR_IDX_MODE, 16'h0002);
      cyc(4);
      chk("gate low", req_valid, 0);
      gate_input <= 1'b1;
      cyc(5);
      chk("gate high", req_valid, 1);
      rdc(`ADCSR_IDX_MODE, 16'h0082, "gate level");
      wr(`ADCSR_IDX_MODE, 16'h0003);
      cyc(3);
      chk("inverted high", req_valid, 0);
      gate_input <= 1'b0;
      cyc(5);
      chk("inverted low", req_valid, 1);
      wr(`ADCSR_IDX_MODE, 16'h0100);
      cyc(20);
   endtask
   task automatic t_trig();
      wr(`ADCSR_IDX_SEL, 16'h0010);
      wr(`ADCSR_IDX_MODE, 16'h0004);
      trigger_input <= 1'b1;
      cyc(6);
      trigger_input <= 1'b0;
      rdc(`ADCSR_IDX_PEND, 16'h0010, "trigger load");
      wr(`ADCSR_IDX_MODE, 16'h0100);
      trigger_input <= 1'b1;
      cyc(6);
      trigger_input <= 1'b0;
      rdc(`ADCSR_IDX_PEND, 16'h0000, "trigger ignored");
   endtask
   task automatic t_abort();
      dly <= 8'h0C;
      abort_en <= 1'b1;
      starts.delete();
      wr(`ADCSR_IDX_MODE, 16'h0001);
      wr(`ADCSR_IDX_PEND, 16'h0002);
      wait_starts(1);
      rdc(`ADCSR_IDX_PEND, 16'h0000, "start clears");
      for (int i = 0; i < 100 && conv_abort !== 1'b1; i++)
         @(posedge sys_clk);
      abort_en <= 1'b0;
      wait_starts(2);
      chk("reissue", starts[1], 4'h1);
      cyc(20);
      dly <= 8'h03;
   endtask
   task automatic t_auto();
      starts.delete();
      wr(`ADCSR_IDX_MODE, 16'h0011);
      wr(`ADCSR_IDX_PEND, 16'h0001);
      wait_starts(3);
      chk("rescan", starts[2], 4'h0);
      wr(`ADCSR_IDX_MODE, 16'h0100);
      cyc(20);
   endtask
   // main sequence
   initial
   begin
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      t_reset();
      t_sel();
      t_load();
      t_seq();
      t_gate();
      t_trig();
      t_abort();
      t_auto();
      conclude();
   end
   // run needs well under 2000 cycles; a hang stops here
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      conclude();
   end
endmodule
